/* verilog/fwa_ctrl.sv */
// Field wake-up, frequency check, activation and SE supply controller
//
// What this block does
// - Idle wait state runs only field detection
// - Field detection starts frequency check, not activation
// - Frequency judged against internal RC oscillator
// - Enable chains only for carrier-band frequency
// - Passing check activates full receive and transmit
// - Software bit enables or disables frequency check
// - Low-power threshold mode forces check off
// - Field loss disables chains, returns to wait
// - Separate wake and deactivation thresholds, hysteresis
// - Detection threshold set through configuration registers
// - Optional automatic SE supply on field presence
// - Optional SE supply while request input high
// - Software directly switches both SE supplies
// - PLL tracks in receive, holds while transmitting
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fwa_ctrl (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [fwa_pkg::AMP_W-1:0] antenna_sense_in_p_i,
  input wire logic [fwa_pkg::AMP_W-1:0] antenna_sense_in_n_i,
  input wire logic carrier_tick_i,
  input wire logic rco_tick_i,
  input wire logic tx_drive_i,
  input wire logic se_supply_request_in_i,
  input wire logic hsel_i,
  input wire logic [fwa_pkg::ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [fwa_pkg::DATA_W-1:0] hwdata_i,
  input wire logic hready_i,
  output logic [fwa_pkg::DATA_W-1:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic rx_en_o,
  output logic tx_en_o,
  output logic fchk_busy_o,
  output logic pll_track_o,
  output logic pll_hold_o,
  output logic contactless_se_supply_out_o,
  output logic wired_se_supply_out_o,
  output logic irq_o
);
  import fwa_pkg::*;

  fwa_state_t state_q;
  fwa_state_t state_d;
  logic [CTRL_W-1:0] ctrl_q;
  logic [AMP_W-1:0] wake_thr_q;
  logic [AMP_W-1:0] deact_thr_q;
  logic [AMP_W-1:0] lp_thr_q;
  logic [EV_W-1:0] sts_q;
  logic [EV_W-1:0] sts_d;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] ev;
  logic armed_q;
  logic field_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;

  // Field amplitude and threshold compare
  logic [AMP_W-1:0] amp;
  logic [AMP_W-1:0] on_thr;
  logic field_on;
  logic field_off;
  logic fchk_use;

  assign amp = (antenna_sense_in_p_i >= antenna_sense_in_n_i) ?
               antenna_sense_in_p_i - antenna_sense_in_n_i :
               antenna_sense_in_n_i - antenna_sense_in_p_i;
  // Low-power mode has its own, higher wake threshold
  assign on_thr = ctrl_q[CTRL_LP_MODE] ? lp_thr_q : wake_thr_q;
  assign field_on = armed_q && (amp > on_thr);
  assign field_off = amp < deact_thr_q;
  // Check only when enabled and not in low-power mode
  assign fchk_use = ctrl_q[CTRL_FCHK_EN] && !ctrl_q[CTRL_LP_MODE];

  // Frequency checker
  logic fc_start;
  logic fc_abort;
  logic fc_done;
  logic fc_pass;

  assign fc_start = (state_q == FWA_WAIT) && field_on && fchk_use;
  assign fc_abort = (state_q == FWA_FCHK) && field_off;

  fwa_freq_chk u_freq_chk (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(fc_start),
    .abort_i(fc_abort),
    .carrier_tick_i(carrier_tick_i),
    .rco_tick_i(rco_tick_i),
    .done_o(fc_done),
    .pass_o(fc_pass)
  );

  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      FWA_WAIT: begin
        if (field_on) begin
          state_d = fchk_use ? FWA_FCHK : FWA_ACT;
        end
      end
      FWA_FCHK: begin
        if (field_off) begin
          state_d = FWA_WAIT;
        end else if (fc_done) begin
          state_d = fc_pass ? FWA_ACT : FWA_WAIT;
        end
      end
      FWA_ACT: begin
        if (field_off) begin
          state_d = FWA_WAIT;
        end
      end
      default: begin
        state_d = FWA_WAIT;
      end
    endcase
  end

  // Events for the sticky status
  assign ev[EV_WAKE] = (state_q == FWA_WAIT) && field_on;
  assign ev[EV_PASS] = (state_q == FWA_FCHK) && fc_done && fc_pass && !field_off;
  assign ev[EV_FAIL] = (state_q == FWA_FCHK) && fc_done && !fc_pass && !field_off;
  assign ev[EV_LOST] = (state_q != FWA_WAIT) && field_off;

  // Bus decode
  logic addr_ph;
  logic wr_en;
  logic [7:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic mapped;
  logic rd_take;

  assign addr_ph = hsel_i && htrans_i[1] && hready_i;
  assign rd_take = addr_ph && !hwrite_i;
  assign wr_en = wr_pend_q;
  assign rd_addr = haddr_i[7:0];
  assign mapped = (haddr_i[ADDR_W-1:8] == '0);

  always_comb begin
    rd_data = '0;
    if (mapped) begin
      case (rd_addr)
        REG_CTRL: rd_data[CTRL_W-1:0] = ctrl_q;
        REG_WAKE_THR: rd_data[AMP_W-1:0] = wake_thr_q;
        REG_DEACT_THR: rd_data[AMP_W-1:0] = deact_thr_q;
        REG_LP_THR: rd_data[AMP_W-1:0] = lp_thr_q;
        REG_STATUS: rd_data[5:0] = {amp > on_thr, field_q, fchk_busy_o, state_q};
        REG_IRQ_STS: rd_data[EV_W-1:0] = sts_q;
        REG_IRQ_MASK: rd_data[EV_W-1:0] = mask_q;
        default: rd_data = '0;
      endcase
    end
  end

  // Write-one-to-clear status; a new event beats a clear in the same cycle
  logic sts_clr_wr;

  assign sts_clr_wr = wr_en && (wr_addr_q == REG_IRQ_STS);

  genvar gi;
  generate
    for (gi = 0; gi < EV_W; gi++) begin : g_sts
      assign sts_d[gi] = ev[gi] || (sts_q[gi] && !(sts_clr_wr && hwdata_i[gi]));
    end
  endgenerate

  // Supply switch terms
  logic se_auto;
  logic se_a_d;
  logic se_w_d;

  assign se_auto = (ctrl_q[CTRL_AUTO_FIELD] && field_q) ||
                   (ctrl_q[CTRL_AUTO_REQ] && se_supply_request_in_i);
  assign se_a_d = ctrl_q[CTRL_SE_A_ON] || se_auto;
  assign se_w_d = ctrl_q[CTRL_SE_W_ON] || se_auto;

  // Bus handshake: zero wait states, always OKAY
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b0;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // Write address carried into the data phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (ce_i) begin
      wr_pend_q <= addr_ph && hwrite_i;
      // Unmapped writes land on an offset nothing decodes
      wr_addr_q <= mapped ? rd_addr : 8'hff;
    end
  end

  // Read data launched at the address phase, stands through the data phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hrdata_o <= '0;
    end else if (ce_i && rd_take) begin
      hrdata_o <= rd_data;
    end
  end

  // Software register write strobes
  logic wr_ctrl;
  logic wr_wake_thr;
  logic wr_deact_thr;
  logic wr_lp_thr;
  logic wr_mask;

  assign wr_ctrl = wr_en && (wr_addr_q == REG_CTRL);
  assign wr_wake_thr = wr_en && (wr_addr_q == REG_WAKE_THR);
  assign wr_deact_thr = wr_en && (wr_addr_q == REG_DEACT_THR);
  assign wr_lp_thr = wr_en && (wr_addr_q == REG_LP_THR);
  assign wr_mask = wr_en && (wr_addr_q == REG_IRQ_MASK);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
    end else if (ce_i && wr_ctrl) begin
      ctrl_q <= hwdata_i[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wake_thr_q <= WAKE_THR_RST;
    end else if (ce_i && wr_wake_thr) begin
      wake_thr_q <= hwdata_i[AMP_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      deact_thr_q <= DEACT_THR_RST;
    end else if (ce_i && wr_deact_thr) begin
      deact_thr_q <= hwdata_i[AMP_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lp_thr_q <= LP_THR_RST;
    end else if (ce_i && wr_lp_thr) begin
      lp_thr_q <= hwdata_i[AMP_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mask_q <= IRQ_MASK_RST;
    end else if (ce_i && wr_mask) begin
      mask_q <= hwdata_i[EV_W-1:0];
    end
  end

  // Sequencer state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= FWA_WAIT;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // A failed check waits for the field to drop before retrying,
  // otherwise a steady off-band signal would restart it forever
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      armed_q <= 1'b1;
    end else if (ce_i) begin
      if (ev[EV_FAIL]) begin
        armed_q <= 1'b0;
      end else if (field_off) begin
        armed_q <= 1'b1;
      end
    end
  end

  // Presence is the hysteresis latch, independent of check result
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      field_q <= 1'b0;
    end else if (ce_i) begin
      if (field_off) begin
        field_q <= 1'b0;
      end else if (amp > on_thr) begin
        field_q <= 1'b1;
      end
    end
  end

  // Sticky status and level interrupt
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sts_q <= '0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      sts_q <= sts_d;
      irq_o <= |(sts_d & mask_q);
    end
  end

  // Chain enables follow the next state so they switch with it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_en_o <= 1'b0;
      tx_en_o <= 1'b0;
      fchk_busy_o <= 1'b0;
    end else if (ce_i) begin
      rx_en_o <= (state_d == FWA_ACT);
      tx_en_o <= (state_d == FWA_ACT);
      fchk_busy_o <= (state_d == FWA_FCHK);
    end
  end

  // Loop opened while driving: extracted clock carries no reader phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pll_track_o <= 1'b0;
      pll_hold_o <= 1'b0;
    end else if (ce_i) begin
      pll_track_o <= (state_d == FWA_ACT) && !tx_drive_i;
      pll_hold_o <= (state_d == FWA_ACT) && tx_drive_i;
    end
  end

  // Supply switches
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      contactless_se_supply_out_o <= 1'b0;
      wired_se_supply_out_o <= 1'b0;
    end else if (ce_i) begin
      contactless_se_supply_out_o <= se_a_d;
      wired_se_supply_out_o <= se_w_d;
    end
  end

endmodule
`default_nettype wire

/* verilog/fwa_pkg.sv */
// Constants for the field wake-up and activation controller
package fwa_pkg;

  localparam int AMP_W = 8;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WAKE_THR = 8'h04;
  localparam logic [7:0] REG_DEACT_THR = 8'h08;
  localparam logic [7:0] REG_LP_THR = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_STS = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;

  // Control register fields
  localparam int CTRL_FCHK_EN = 0;
  localparam int CTRL_LP_MODE = 1;
  localparam int CTRL_AUTO_FIELD = 2;
  localparam int CTRL_AUTO_REQ = 3;
  localparam int CTRL_SE_A_ON = 4;
  localparam int CTRL_SE_W_ON = 5;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h01;

  // Threshold reset values
  localparam logic [AMP_W-1:0] WAKE_THR_RST = 8'h40;
  localparam logic [AMP_W-1:0] DEACT_THR_RST = 8'h10;
  localparam logic [AMP_W-1:0] LP_THR_RST = 8'h80;

  // Interrupt event bits
  localparam int EV_WAKE = 0;
  localparam int EV_PASS = 1;
  localparam int EV_FAIL = 2;
  localparam int EV_LOST = 3;
  localparam int EV_W = 4;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;

  // Frequency check window in oscillator ticks, pass band limits in carrier ticks
  localparam int FC_RCO_W = 8;
  localparam int FC_CNT_W = 10;
  localparam logic [FC_RCO_W-1:0] FC_WIN = 8'h20;
  localparam logic [FC_CNT_W-1:0] FC_LO = 10'h102;
  localparam logic [FC_CNT_W-1:0] FC_HI = 10'h11d;

  typedef enum logic [2:0] {
    FWA_WAIT = 3'b001,
    FWA_FCHK = 3'b010,
    FWA_ACT = 3'b100
  } fwa_state_t;

endpackage

/* verilog/fwa_freq_chk.sv */
// Carrier frequency checker against the RC oscillator time base
`timescale 1ns/1ps
`default_nettype none
module fwa_freq_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic carrier_tick_i,
  input wire logic rco_tick_i,
  output logic done_o,
  output logic pass_o
);
  import fwa_pkg::*;

  logic busy_q;
  logic [FC_RCO_W-1:0] rco_cnt_q;
  logic [FC_CNT_W-1:0] car_cnt_q;
  logic [FC_CNT_W-1:0] car_next;
  logic win_end;

  // Saturate so a noisy fast input cannot wrap into the band
  assign car_next = (carrier_tick_i && car_cnt_q != '1) ?
                    car_cnt_q + {{(FC_CNT_W-1){1'b0}}, 1'b1} : car_cnt_q;
  assign win_end = busy_q && rco_tick_i && (rco_cnt_q == FC_WIN - 8'h01);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      rco_cnt_q <= '0;
      car_cnt_q <= '0;
      done_o <= 1'b0;
      pass_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= win_end && !abort_i;
      if (start_i) begin
        busy_q <= 1'b1;
        rco_cnt_q <= '0;
        car_cnt_q <= '0;
      end else if (abort_i || win_end) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        car_cnt_q <= car_next;
        if (rco_tick_i) begin
          rco_cnt_q <= rco_cnt_q + 8'h01;
        end
      end
      if (win_end) begin
        pass_o <= (car_next >= FC_LO) && (car_next <= FC_HI);
      end
    end
  end
endmodule
`default_nettype wire

/* verification/fwa_ctrl_sva.sv */
// Port checker for the field wake-up and activation controller
`timescale 1ns/1ps
`default_nettype none
module fwa_ctrl_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [fwa_pkg::AMP_W-1:0] antenna_sense_in_p_i,
  input wire logic [fwa_pkg::AMP_W-1:0] antenna_sense_in_n_i,
  input wire logic tx_drive_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic rx_en_o,
  input wire logic tx_en_o,
  input wire logic fchk_busy_o,
  input wire logic pll_track_o,
  input wire logic pll_hold_o
);
  import fwa_pkg::*;
  logic [AMP_W-1:0] amp;
  assign amp = (antenna_sense_in_p_i > antenna_sense_in_n_i) ?
    antenna_sense_in_p_i - antenna_sense_in_n_i : antenna_sense_in_n_i - antenna_sense_in_p_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_OKAY: assert property (hresp_o == 1'b0) else $error("hresp not okay");
  AST_RDY: assert property ($past(rst_n_i) |-> hreadyout_o) else $error("wait state seen");
  AST_PAIR: assert property (rx_en_o == tx_en_o) else $error("rx and tx enables differ");
  AST_EXCL: assert property (!(fchk_busy_o && rx_en_o)) else $error("check while active");
  // Holds only while the deactivation threshold is nonzero
  AST_QUIET: assert property (amp == 8'h00 |=> !rx_en_o && !fchk_busy_o)
    else $error("active without field");
  AST_WAKE: assert property ($rose(fchk_busy_o) |-> $past(amp) != 8'h00)
    else $error("check started without field");
  AST_HOLD: assert property ($past(rx_en_o) && rx_en_o && $past(tx_drive_i)
    |-> pll_hold_o && !pll_track_o) else $error("pll not held in transmit");
  AST_TRACK: assert property ($past(rx_en_o) && rx_en_o && !$past(tx_drive_i)
    |-> pll_track_o && !pll_hold_o) else $error("pll not tracking in receive");
  AST_PLL_IDLE: assert property (!rx_en_o && !$past(rx_en_o) |-> !pll_hold_o && !pll_track_o)
    else $error("pll busy while idle");
  COV_ACT: cover property ($rose(rx_en_o));
  COV_CHK: cover property ($rose(fchk_busy_o));
  COV_HOLD: cover property ($rose(pll_hold_o));
endmodule
bind fwa_ctrl fwa_ctrl_sva sva_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .antenna_sense_in_p_i(antenna_sense_in_p_i), .antenna_sense_in_n_i(antenna_sense_in_n_i),
  .tx_drive_i(tx_drive_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rx_en_o(rx_en_o),
  .tx_en_o(tx_en_o), .fchk_busy_o(fchk_busy_o), .pll_track_o(pll_track_o),
  .pll_hold_o(pll_hold_o));
`default_nettype wire

/* verification/fwa_field_model.sv */
// Reader field and oscillator tick source for the controller bench
`timescale 1ns/1ps
`default_nettype none
module fwa_field_model (
  input wire logic clk_i,
  input wire logic [fwa_pkg::AMP_W-1:0] amp_i,
  input wire logic [2:0] div_i,
  output logic [fwa_pkg::AMP_W-1:0] sense_p_o,
  output logic [fwa_pkg::AMP_W-1:0] sense_n_o,
  output logic carrier_tick_o,
  output logic rco_tick_o
);
  import fwa_pkg::*;
  logic [2:0] car_q = 3'h0;
  logic [4:0] rco_q = 5'h0;
  // Common-mode offset so amplitude is a true difference
  assign sense_n_o = 8'h10;
  assign sense_p_o = amp_i + 8'h10;
  // Carrier stops with the field, never runs between fields
  assign carrier_tick_o = (amp_i != 8'h00) && (car_q == 3'h0);
  assign rco_tick_o = (rco_q == 5'h0);
  always_ff @(posedge clk_i) begin
    car_q <= (car_q + 3'h1 >= div_i) ? 3'h0 : car_q + 3'h1;
    rco_q <= (rco_q == 5'h10) ? 5'h0 : rco_q + 5'h1;
  end
endmodule
`default_nettype wire

/* verification/test_field_wakeup_activation_ctrl.sv */
// Self-checking bench for the field wake-up and activation controller
`timescale 1ns/1ps
`default_nettype none
module test_field_wakeup_activation_ctrl;
  import fwa_pkg::*;
  logic clk_i, rst_n_i, tx_drv, se_req, hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata;
  logic [7:0] amp;
  logic [2:0] div;
  wire logic [7:0] sp, sn;
  wire logic ctk, rtk, rdy, rx_en, tx_en, hresp, busy, trk, hld, se_a, se_w, irq;
  wire logic [31:0] hrdata;
  int errors, n_tests;
  logic [31:0] ra [9] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h14, 32'h18, 32'h1c, 32'h100};
  logic [31:0] rv [9] = '{32'h1, 32'h40, 32'h10, 32'h80, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
  fwa_field_model fld_u (.clk_i(clk_i), .amp_i(amp), .div_i(div), .sense_p_o(sp),
    .sense_n_o(sn), .carrier_tick_o(ctk), .rco_tick_o(rtk));
  fwa_ctrl dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .antenna_sense_in_p_i(sp),
    .antenna_sense_in_n_i(sn), .carrier_tick_i(ctk), .rco_tick_i(rtk), .tx_drive_i(tx_drv),
    .se_supply_request_in_i(se_req), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata),
    .hreadyout_o(rdy), .hresp_o(hresp), .rx_en_o(rx_en), .tx_en_o(tx_en), .fchk_busy_o(busy),
    .pll_track_o(trk), .pll_hold_o(hld), .contactless_se_supply_out_o(se_a),
    .wired_se_supply_out_o(se_w), .irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task give_verdict();
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic logic pick(input int s);
    return (s == 0) ? rx_en : busy;
  endfunction
  // Bounded wait; a hang ends the run as a failure
  task wait_for(input int s, input logic v, input int lim);
    for (int k = 0; pick(s) !== v; k++) begin
      if (k == lim) begin
        errors++;
        give_verdict();
      end
      @(posedge clk_i);
    end
  endtask
  // Bus handshake wait, bounded like every other wait
  task wait_rdy();
    for (int k = 0; rdy !== 1'b1; k++) begin
      if (k == 50) begin
        errors++;
        give_verdict();
      end
      @(posedge clk_i);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_i);
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_i);
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, {24'h0, a}, d, x);
  endtask
  task rchk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk($sformatf("reg_%h", a), e, x);
  endtask
  task se_case(input logic [7:0] c, input logic rq, input logic ea, input logic ew);
    wr(REG_CTRL, {24'h0, c});
    se_req <= rq;
    idle(3);
    chk("se_a", 32'(ea), 32'(se_a));
    chk("se_w", 32'(ew), 32'(se_w));
  endtask
  initial begin
    {rst_n_i, tx_drv, se_req, hwrite} = 4'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    amp = 8'h00;
    div = 3'h2;
    errors = 0;
    n_tests = 0;
    idle(20);
    rst_n_i <= 1'b1;
    idle(2);
    for (int i = 0; i < 9; i++) rchk(ra[i], rv[i]);
    se_case(8'h11, 1'b0, 1'b1, 1'b0);
    se_case(8'h21, 1'b0, 1'b0, 1'b1);
    se_case(8'h09, 1'b1, 1'b1, 1'b1);
    se_case(8'h09, 1'b0, 1'b0, 1'b0);
    wr(REG_CTRL, 32'h05);
    amp <= 8'h50;
    wait_for(1, 1'b1, 5);
    chk("rx_en", 32'h0, 32'(rx_en));
    wait_for(0, 1'b1, 800);
    chk("tx_en", 32'h1, 32'(tx_en));
    chk("se_a", 32'h1, 32'(se_a));
    rchk(32'(REG_IRQ_STS), 32'h3);
    wr(REG_IRQ_MASK, 32'h2);
    idle(2);
    chk("irq", 32'h1, 32'(irq));
    wr(REG_IRQ_STS, 32'h3);
    idle(2);
    chk("irq", 32'h0, 32'(irq));
    amp <= 8'h20;
    idle(20);
    chk("rx_en", 32'h1, 32'(rx_en));
    tx_drv <= 1'b1;
    idle(3);
    chk("pll", 32'h2, {30'h0, hld, trk});
    tx_drv <= 1'b0;
    idle(3);
    chk("pll", 32'h1, {30'h0, hld, trk});
    amp <= 8'h00;
    wait_for(0, 1'b0, 5);
    chk("tx_en", 32'h0, 32'(tx_en));
    rchk(32'(REG_STATUS), 32'h1);
    rchk(32'(REG_IRQ_STS), 32'h8);
    wr(REG_IRQ_STS, 32'hf);
    div <= 3'h4;
    amp <= 8'h50;
    wait_for(1, 1'b1, 5);
    wait_for(1, 1'b0, 800);
    idle(3);
    chk("rx_en", 32'h0, 32'(rx_en));
    rchk(32'(REG_IRQ_STS), 32'h5);
    amp <= 8'h00;
    div <= 3'h2;
    wr(REG_WAKE_THR, 32'h60);
    wr(REG_CTRL, 32'h00);
    amp <= 8'h50;
    idle(10);
    chk("rx_en", 32'h0, 32'(rx_en));
    amp <= 8'h70;
    wait_for(0, 1'b1, 3);
    amp <= 8'h00;
    wait_for(0, 1'b0, 5);
    wr(REG_CTRL, 32'h03);
    amp <= 8'h70;
    idle(10);
    chk("rx_en", 32'h0, 32'(rx_en));
    amp <= 8'h90;
    wait_for(0, 1'b1, 3);
    give_verdict();
  end
endmodule
`default_nettype wire
